// ---- src/scr_device.sv ----
// Device end: 3-wire register write port with status readback.
//
// What this block does
// - Control pin low selects software, high hardware.
// - Wire-count pin low two-wire, high three-wire.
// - Sample serial input on serial clock rising.
// - Write word: 7-bit address, 9-bit data.
// - Chip select rising edge commits shifted word.
// - Controller may hold select low or pulse.
// - Only ID and status registers read back.
// - Serial output answers only when readback enabled.
// - Continuous bit one selects continuous readback.
// - Continuous: every write returns selected status byte.
// - Selector: error, channel one-five, S/PDIF status.
// - First read after writes already returns valid data.
// - Later reads stay valid until next write.
// - Output released whenever chip select high.
// - Reset clears enable, continuous and selector.
// - Non-continuous: write returns addressed register.
`timescale 1ns/10ps
module scr_device
  import scr_pkg::*;
#(
  parameter logic [7:0] ID0_VALUE        = 8'h11, // Arbitrary identification value.
  parameter logic [7:0] ID1_VALUE        = 8'h22, // Arbitrary identification value.
  parameter logic [7:0] ID2_VALUE        = 8'h33, // Arbitrary identification value.
  parameter logic [6:0] STATUS_ADDR_BASE = 7'h38  // Address of the first of the seven status registers.
) (
  input  wire logic         ref_clk,                   // Reference clock, 40 MHz.
  input  wire logic         reset,                     // Asynchronous reset, active high.
  scr_if.device             link,                      // Serial control link pins.
  input  wire logic         control_method_select,     // Pin: low software, high hardware control.
  input  wire logic         serial_wire_count_select,  // Pin: low 2-wire, high 3-wire.
  input  wire logic [7:0]   error_status,              // Error register contents.
  input  wire logic [39:0]  channel_status,            // Channel status registers one to five, one at bits 7:0.
  input  wire logic [7:0]   spdif_status,              // S/PDIF status register contents.
  output logic              reg_wr_strobe,             // One-cycle pulse: a full word was committed.
  output logic [ADDR_W-1:0] reg_wr_addr,               // Address of the committed word.
  output logic [DATA_W-1:0] reg_wr_data,               // Data of the committed word.
  output logic              readback_enable,           // Readback control enable bit.
  output logic              continuous_readback,       // Readback control continuous bit.
  output logic [2:0]        readback_source_select,    // Readback control source selector.
  output logic              software_mode,             // Filtered level: software control active.
  output logic              three_wire_mode            // Filtered level: 3-wire software mode active.
);

  localparam int NPIN = 5;
  localparam int P_CS = 0;
  localparam int P_CK = 1;
  localparam int P_DI = 2;
  localparam int P_HW = 3;
  localparam int P_SW = 4;

  logic [NPIN-1:0]        pin_raw;
  logic [NPIN-1:0]        lvl_r;
  logic [NPIN-1:0]        lvl_nxt;
  logic [SYNC_STAGES-1:0] sync_r [NPIN];

  logic [WORD_W-1:0]      shift_r;
  logic [WORD_W-1:0]      shift_nxt;
  logic [CNT_W-1:0]       cnt_r;
  logic [CNT_W-1:0]       cnt_nxt;
  logic                   en_r;
  logic                   en_nxt;
  logic                   cont_r;
  logic                   cont_nxt;
  logic [2:0]             sel_r;
  logic [2:0]             sel_nxt;
  logic [ADDR_W-1:0]      last_addr_r;
  logic [ADDR_W-1:0]      last_addr_nxt;
  logic [BYTE_W-1:0]      tx_r;
  logic [BYTE_W-1:0]      tx_nxt;
  logic                   tx_ok_r;
  logic                   tx_ok_nxt;
  logic                   wr_r;
  logic                   wr_nxt;
  logic [ADDR_W-1:0]      wr_addr_r;
  logic [ADDR_W-1:0]      wr_addr_nxt;
  logic [DATA_W-1:0]      wr_data_r;
  logic [DATA_W-1:0]      wr_data_nxt;

  logic [BYTE_W-1:0]      src [SRC_NUM];
  logic                   active;
  logic                   sclk_rise;
  logic                   sclk_fall;
  logic                   cs_rise;
  logic                   cs_fall;
  logic                   commit;
  logic [ADDR_W-1:0]      look_addr;
  logic [BYTE_W-1:0]      look_byte;
  logic                   look_ok;
  logic [ADDR_W-1:0]      stat_off;

  assign pin_raw = {serial_wire_count_select, control_method_select,
                    link.serial_in_line, link.serial_clock, link.chip_select_n};

  // Each pin passes three flops; a new level counts once the last two agree.
  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          sync_r[i] <= {SYNC_STAGES{(i == P_CS) ? 1'b1 : 1'b0}};
        end else begin
          sync_r[i] <= {sync_r[i][SYNC_STAGES-2:0], pin_raw[i]};
        end
      end
      assign lvl_nxt[i] = (sync_r[i][SYNC_STAGES-1] == sync_r[i][SYNC_STAGES-2]) ?
                          sync_r[i][SYNC_STAGES-1] : lvl_r[i];
    end
  endgenerate

  // Status sources in selector order.
  assign src[0] = error_status;
  assign src[1] = channel_status[7:0];
  assign src[2] = channel_status[15:8];
  assign src[3] = channel_status[23:16];
  assign src[4] = channel_status[31:24];
  assign src[5] = channel_status[39:32];
  assign src[6] = spdif_status;

  // Mode decode and link edge detection on the filtered levels.
  assign active    = ~lvl_r[P_HW] & lvl_r[P_SW];
  assign sclk_rise = active & lvl_nxt[P_CK] & ~lvl_r[P_CK];
  assign sclk_fall = active & ~lvl_nxt[P_CK] & lvl_r[P_CK];
  assign cs_rise   = active & lvl_nxt[P_CS] & ~lvl_r[P_CS];
  assign cs_fall   = active & ~lvl_nxt[P_CS] & lvl_r[P_CS];
  assign commit    = cs_rise && (cnt_r == CNT_W'(WORD_W));

  // Content of the register addressed by a committed word or the last write.
  always_comb begin
    look_addr = commit ? shift_r[WORD_W-1 -: ADDR_W] : last_addr_r;
    stat_off  = look_addr - STATUS_ADDR_BASE;
    look_byte = 8'h00;
    look_ok   = 1'b0;
    if (look_addr == ID0_ADDR) begin
      look_byte = ID0_VALUE;
      look_ok   = 1'b1;
    end else if (look_addr == ID1_ADDR) begin
      look_byte = ID1_VALUE;
      look_ok   = 1'b1;
    end else if (look_addr == ID2_ADDR) begin
      look_byte = ID2_VALUE;
      look_ok   = 1'b1;
    end else if (look_addr >= STATUS_ADDR_BASE && stat_off < ADDR_W'(SRC_NUM)) begin
      look_byte = src[stat_off[2:0]];
      look_ok   = 1'b1;
    end
  end

  // Next state of the shifter, control register and readback byte.
  always_comb begin
    shift_nxt     = shift_r;
    cnt_nxt       = cnt_r;
    en_nxt        = en_r;
    cont_nxt      = cont_r;
    sel_nxt       = sel_r;
    last_addr_nxt = last_addr_r;
    tx_nxt        = tx_r;
    tx_ok_nxt     = tx_ok_r;
    wr_nxt        = 1'b0;
    wr_addr_nxt   = wr_addr_r;
    wr_data_nxt   = wr_data_r;
    if (!active) begin
      cnt_nxt = '0;
    end else if (cs_rise) begin
      cnt_nxt   = '0;
      shift_nxt = '0;
      if (commit) begin
        wr_nxt        = 1'b1;
        wr_addr_nxt   = shift_r[WORD_W-1 -: ADDR_W];
        wr_data_nxt   = shift_r[DATA_W-1:0];
        last_addr_nxt = shift_r[WORD_W-1 -: ADDR_W];
        if (shift_r[WORD_W-1 -: ADDR_W] == READBACK_CTRL_ADDR) begin
          en_nxt   = shift_r[RB_ENABLE_BIT];
          cont_nxt = shift_r[RB_CONT_BIT];
          sel_nxt  = shift_r[RB_SEL_LSB +: RB_SEL_W];
        end
        if (cont_nxt) begin
          tx_nxt    = (sel_nxt <= SRC_SPDIF) ? src[sel_nxt] : 8'h00;
          tx_ok_nxt = en_nxt && (sel_nxt <= SRC_SPDIF);
        end else begin
          tx_nxt    = look_byte;
          tx_ok_nxt = en_nxt && look_ok;
        end
      end
    end else begin
      if (sclk_rise) begin
        shift_nxt = {shift_r[WORD_W-2:0], lvl_r[P_DI]};
        cnt_nxt   = (cnt_r == CNT_W'(WORD_W)) ? cnt_r : cnt_r + 1'b1;
      end
      if (cs_fall) begin
        // Fresh copy at every read start keeps repeated reads valid.
        if (cont_r) begin
          tx_nxt    = (sel_r <= SRC_SPDIF) ? src[sel_r] : 8'h00;
          tx_ok_nxt = en_r && (sel_r <= SRC_SPDIF);
        end else begin
          tx_nxt    = look_byte;
          tx_ok_nxt = en_r && look_ok;
        end
      end else if (sclk_fall && !lvl_r[P_CS]) begin
        tx_nxt = {tx_r[BYTE_W-2:0], 1'b0};
      end
    end
  end

  // Registers of the port; readback control resets to disabled.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lvl_r       <= 5'h01;
      shift_r     <= '0;
      cnt_r       <= '0;
      en_r        <= RB_ENABLE_RST;
      cont_r      <= RB_CONT_RST;
      sel_r       <= RB_SEL_RST;
      last_addr_r <= '0;
      tx_r        <= '0;
      tx_ok_r     <= 1'b0;
      wr_r        <= 1'b0;
      wr_addr_r   <= '0;
      wr_data_r   <= '0;
    end else begin
      lvl_r       <= lvl_nxt;
      shift_r     <= shift_nxt;
      cnt_r       <= cnt_nxt;
      en_r        <= en_nxt;
      cont_r      <= cont_nxt;
      sel_r       <= sel_nxt;
      last_addr_r <= last_addr_nxt;
      tx_r        <= tx_nxt;
      tx_ok_r     <= tx_ok_nxt;
      wr_r        <= wr_nxt;
      wr_addr_r   <= wr_addr_nxt;
      wr_data_r   <= wr_data_nxt;
    end
  end

  // Output line is driven only in 3-wire mode with select low and readback armed.
  assign link.serial_out_line_oe_n = ~(active & ~lvl_r[P_CS] & tx_ok_r);
  assign link.serial_out_line_drv  = tx_r[BYTE_W-1];

  assign reg_wr_strobe          = wr_r;
  assign reg_wr_addr            = wr_addr_r;
  assign reg_wr_data            = wr_data_r;
  assign readback_enable        = en_r;
  assign continuous_readback    = cont_r;
  assign readback_source_select = sel_r;
  assign software_mode          = ~lvl_r[P_HW];
  assign three_wire_mode        = active;

endmodule

// ---- src/scr_host.sv ----
// Controller end: issues 3-wire writes and 8-bit reads on the serial link.
`timescale 1ns/10ps
module scr_host
  import scr_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC  // Reference cycles per serial clock half period.
) (
  input  wire logic              ref_clk,    // Reference clock, 40 MHz.
  input  wire logic              reset,      // Asynchronous reset, active high.
  scr_if.host                    link,       // Serial control link pins.
  input  wire logic              cmd_valid,  // Command request.
  output logic                   cmd_ready,  // High when idle and a command is taken.
  input  wire logic              cmd_read,   // 1 read a byte, 0 write a word.
  input  wire logic [ADDR_W-1:0] cmd_addr,   // Write address.
  input  wire logic [DATA_W-1:0] cmd_data,   // Write data.
  output logic                   rsp_valid,  // One-cycle pulse: read byte ready.
  output logic [BYTE_W-1:0]      rsp_data    // Byte read back.
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LOW  = 5'b00010,
    ST_HIGH = 5'b00100,
    ST_TAIL = 5'b01000,
    ST_GAP  = 5'b10000
  } scr_host_st_e;

  localparam int TW = $clog2(HALF_CYC + 1);

  scr_host_st_e          st_r;
  scr_host_st_e          st_nxt;
  logic [TW-1:0]         tmr_r;
  logic [TW-1:0]         tmr_nxt;
  logic [CNT_W-1:0]      left_r;
  logic [CNT_W-1:0]      left_nxt;
  logic [WORD_W-1:0]     sh_r;
  logic [WORD_W-1:0]     sh_nxt;
  logic [BYTE_W-1:0]     rx_r;
  logic [BYTE_W-1:0]     rx_nxt;
  logic                  rd_r;
  logic                  rd_nxt;
  logic                  cs_n_r;
  logic                  cs_n_nxt;
  logic                  sclk_r;
  logic                  sclk_nxt;
  logic                  rv_r;
  logic                  rv_nxt;
  logic [SYNC_STAGES-1:0] sdo_sync_r;
  logic                  sdo_lvl_r;
  logic                  tick;

  // Returned line passes three flops; a level counts once the last two agree.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sdo_sync_r <= {SYNC_STAGES{1'b1}};
      sdo_lvl_r  <= 1'b1;
    end else begin
      sdo_sync_r <= {sdo_sync_r[SYNC_STAGES-2:0], link.serial_out_line};
      if (sdo_sync_r[SYNC_STAGES-1] == sdo_sync_r[SYNC_STAGES-2]) begin
        sdo_lvl_r <= sdo_sync_r[SYNC_STAGES-1];
      end
    end
  end

  assign tick      = (tmr_r == TW'(HALF_CYC - 1));
  assign cmd_ready = (st_r == ST_IDLE);

  // Sequencer: data changes on clock low, the device samples on the rise.
  always_comb begin
    st_nxt   = st_r;
    tmr_nxt  = tick ? '0 : tmr_r + 1'b1;
    left_nxt = left_r;
    sh_nxt   = sh_r;
    rx_nxt   = rx_r;
    rd_nxt   = rd_r;
    cs_n_nxt = cs_n_r;
    sclk_nxt = sclk_r;
    rv_nxt   = 1'b0;
    case (st_r)
      ST_IDLE: begin
        tmr_nxt = '0;
        if (cmd_valid) begin
          rd_nxt   = cmd_read;
          sh_nxt   = {cmd_addr, cmd_data};
          left_nxt = cmd_read ? CNT_W'(BYTE_W) : CNT_W'(WORD_W);
          cs_n_nxt = 1'b0;
          st_nxt   = ST_LOW;
        end
      end
      ST_LOW: begin
        if (tick) begin
          sclk_nxt = 1'b1;
          st_nxt   = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (tick) begin
          sclk_nxt = 1'b0;
          rx_nxt   = {rx_r[BYTE_W-2:0], sdo_lvl_r};
          sh_nxt   = {sh_r[WORD_W-2:0], 1'b0};
          left_nxt = left_r - 1'b1;
          st_nxt   = (left_r == CNT_W'(1)) ? ST_TAIL : ST_LOW;
        end
      end
      ST_TAIL: begin
        if (tick) begin
          cs_n_nxt = 1'b1;
          rv_nxt   = rd_r;
          st_nxt   = ST_GAP;
        end
      end
      ST_GAP: begin
        if (tick) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt   = ST_IDLE;
        cs_n_nxt = 1'b1;
        sclk_nxt = 1'b0;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r   <= ST_IDLE;
      tmr_r  <= '0;
      left_r <= '0;
      sh_r   <= '0;
      rx_r   <= '0;
      rd_r   <= 1'b0;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      rv_r   <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      tmr_r  <= tmr_nxt;
      left_r <= left_nxt;
      sh_r   <= sh_nxt;
      rx_r   <= rx_nxt;
      rd_r   <= rd_nxt;
      cs_n_r <= cs_n_nxt;
      sclk_r <= sclk_nxt;
      rv_r   <= rv_nxt;
    end
  end

  assign link.chip_select_n  = cs_n_r;
  assign link.serial_clock   = sclk_r;
  assign link.serial_in_line = sh_r[WORD_W-1];
  assign rsp_valid           = rv_r;
  assign rsp_data            = rx_r;

endmodule

// ---- src/scr_if.sv ----
// Interface joining the controller end and the device end of the 3-wire link.
`timescale 1ns/10ps
interface scr_if;
  logic chip_select_n;
  logic serial_clock;
  logic serial_in_line;
  logic serial_out_line_drv;
  logic serial_out_line_oe_n;
  logic serial_out_line;

  // Released output line is modelled as pulled high.
  assign serial_out_line = serial_out_line_oe_n ? 1'b1 : serial_out_line_drv;

  modport device (
    input  chip_select_n,
    input  serial_clock,
    input  serial_in_line,
    output serial_out_line_drv,
    output serial_out_line_oe_n
  );

  modport host (
    output chip_select_n,
    output serial_clock,
    output serial_in_line,
    input  serial_out_line
  );
endinterface

// ---- src/scr_pkg.sv ----
// Shared constants for the serial control and readback port.
package scr_pkg;
  // Word layout of a 3-wire write.
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 5;

  // Register addresses.
  localparam logic [6:0] READBACK_CTRL_ADDR = 7'h34;
  localparam logic [6:0] ID0_ADDR           = 7'h00;
  localparam logic [6:0] ID1_ADDR           = 7'h01;
  localparam logic [6:0] ID2_ADDR           = 7'h02;

  // Readback control field positions and reset values.
  localparam int         RB_ENABLE_BIT = 4;
  localparam int         RB_CONT_BIT   = 3;
  localparam int         RB_SEL_LSB    = 0;
  localparam int         RB_SEL_W      = 3;
  localparam logic       RB_ENABLE_RST = 1'b0;
  localparam logic       RB_CONT_RST   = 1'b0;
  localparam logic [2:0] RB_SEL_RST    = 3'h0;

  // Readback source codes.
  localparam logic [2:0] SRC_ERROR = 3'h0;
  localparam logic [2:0] SRC_SPDIF = 3'h6;
  localparam int         SRC_NUM   = 7;

  // Timing: reference clock and serial clock half period.
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SCLK_HALF_NS  = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_STAGES   = 3;
endpackage

// ---- tb/scr_props.sv ----
// Concurrent checks on the 3-wire link between the two ends.
`timescale 1ns/10ps
module scr_props (
  input wire logic ref_clk,              // Reference clock.
  input wire logic reset,                // Asynchronous reset, active high.
  input wire logic chip_select_n,        // Select, active low.
  input wire logic serial_clock,         // Serial clock.
  input wire logic serial_in_line,       // Controller data.
  input wire logic serial_out_line_drv,  // Device data.
  input wire logic serial_out_line_oe_n, // Device enable, active low.
  input wire logic serial_out_line       // Resolved output line.
);
  logic       sclk_q_r;
  logic       sclk_q_nxt;
  logic [4:0] rise_r;
  logic [4:0] rise_nxt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Counts serial clock rises inside one select-low frame.
  always_comb begin
    sclk_q_nxt = serial_clock;
    rise_nxt   = chip_select_n ? 5'h00 : rise_r + 5'(serial_clock & ~sclk_q_r);
  end

  // Registers the frame counter.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclk_q_r <= 1'b0;
      rise_r   <= 5'h00;
    end else begin
      sclk_q_r <= sclk_q_nxt;
      rise_r   <= rise_nxt;
    end
  end

  chk_idle_clock_low: assert property (chip_select_n |-> !serial_clock)
    else $error("serial clock high outside a frame");
  chk_data_stable_high: assert property (serial_clock |-> $stable(serial_in_line))
    else $error("input data moved while serial clock high");
  chk_clock_high_width: assert property ($rose(serial_clock) |-> serial_clock [*8] ##1 !serial_clock)
    else $error("serial clock high phase not eight cycles");
  chk_first_edge_delay: assert property ($fell(chip_select_n) |-> !serial_clock [*8] ##1 serial_clock)
    else $error("first serial clock rise misplaced");
  chk_frame_bit_count: assert property ($rose(chip_select_n) |-> (rise_r == 5'h10 || rise_r == 5'h08))
    else $error("frame closed with a wrong bit count");
  chk_out_released: assert property (chip_select_n [*8] |-> serial_out_line_oe_n)
    else $error("output driven while select high");
  chk_out_needs_select: assert property ($fell(serial_out_line_oe_n) |-> !chip_select_n)
    else $error("output enabled without select");
  chk_out_stable_high: assert property ((!serial_out_line_oe_n && serial_clock && $past(serial_clock))
      |-> $stable(serial_out_line_drv) && serial_out_line == serial_out_line_drv)
    else $error("output data moved while serial clock high");
endmodule

// ---- tb/serial_control_readback_port_bench.sv ----
// Self-checking bench joining the controller end and the device end.
`timescale 1ns/10ps
module serial_control_readback_port_bench
  import scr_pkg::*;
;
  typedef struct packed {
    logic              rd;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [7:0]        e;
  } scr_row_s;

  logic              ref_clk;
  logic              reset;
  logic              control_method_select;
  logic              serial_wire_count_select;
  logic [7:0]        error_status;
  logic [39:0]       channel_status;
  logic [7:0]        spdif_status;
  logic              reg_wr_strobe;
  logic [ADDR_W-1:0] reg_wr_addr;
  logic [DATA_W-1:0] reg_wr_data;
  logic              readback_enable;
  logic              continuous_readback;
  logic [2:0]        readback_source_select;
  logic              software_mode;
  logic              three_wire_mode;
  logic              cmd_valid;
  logic              cmd_ready;
  logic              cmd_read;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_data;
  logic              rsp_valid;
  logic [BYTE_W-1:0] rsp_data;
  logic [4:0]        exp_rb;
  int                fails;
  int                total_checks;
  int                cycles;
  int                strobes;
  int                nrsp;
  int                ds;
  int                dr;

  // Ordinary traffic: one write, then the byte the following read must return.
  localparam scr_row_s ROWS [19] = '{
    '{1'b0, 7'h00, 9'h0aa, 8'h00}, '{1'b1, 7'h00, 9'h000, 8'hff},
    '{1'b0, 7'h34, 9'h010, 8'h00}, '{1'b1, 7'h00, 9'h000, 8'hff},
    '{1'b0, 7'h01, 9'h000, 8'h00}, '{1'b1, 7'h00, 9'h000, 8'h22}, '{1'b1, 7'h00, 9'h000, 8'h22},
    '{1'b0, 7'h02, 9'h000, 8'h00}, '{1'b1, 7'h00, 9'h000, 8'h33},
    '{1'b0, 7'h00, 9'h000, 8'h00}, '{1'b1, 7'h00, 9'h000, 8'h11},
    '{1'b0, 7'h3a, 9'h000, 8'h00}, '{1'b1, 7'h00, 9'h000, 8'hc3},
    '{1'b0, 7'h3e, 9'h000, 8'h00}, '{1'b1, 7'h00, 9'h000, 8'h5a},
    '{1'b0, 7'h38, 9'h000, 8'h00}, '{1'b1, 7'h00, 9'h000, 8'ha5},
    '{1'b0, 7'h40, 9'h000, 8'h00}, '{1'b1, 7'h00, 9'h000, 8'hff}
  };

  scr_if lnk ();
  scr_device i_scr_device (.ref_clk(ref_clk), .reset(reset), .link(lnk),
    .control_method_select(control_method_select), .serial_wire_count_select(serial_wire_count_select),
    .error_status(error_status), .channel_status(channel_status), .spdif_status(spdif_status),
    .reg_wr_strobe(reg_wr_strobe), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .readback_enable(readback_enable), .continuous_readback(continuous_readback),
    .readback_source_select(readback_source_select), .software_mode(software_mode),
    .three_wire_mode(three_wire_mode));
  scr_host #(.HALF_CYC(8)) i_scr_host (.ref_clk(ref_clk), .reset(reset), .link(lnk),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  scr_props i_scr_props (.ref_clk(ref_clk), .reset(reset), .chip_select_n(lnk.chip_select_n),
    .serial_clock(lnk.serial_clock), .serial_in_line(lnk.serial_in_line),
    .serial_out_line_drv(lnk.serial_out_line_drv), .serial_out_line_oe_n(lnk.serial_out_line_oe_n),
    .serial_out_line(lnk.serial_out_line));

  // Makes the 40 MHz reference clock.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Counts cycles, commits and read answers, and cuts a hang short.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (reg_wr_strobe === 1'b1) strobes <= strobes + 1;
    if (rsp_valid === 1'b1) nrsp <= nrsp + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      results();
    end
  end

  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic logic [7:0] src(input int k);
    if (k == 0) return error_status;
    if (k <= 5) return channel_status[8*k-1 -: 8];
    if (k == 6) return spdif_status;
    return 8'hff;
  endfunction

  // Issues one command, waits for the controller to go idle and for the commit to land.
  task automatic cmd(input logic rd, input logic [6:0] a, input logic [8:0] d);
    int s0;
    int r0;
    s0 = strobes;
    r0 = nrsp;
    while (cmd_ready !== 1'b1) begin
      @(posedge ref_clk);
      #2;
    end
    cmd_read = rd;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge ref_clk);
    #2;
    cmd_valid = 1'b0;
    while (cmd_ready !== 1'b1) begin
      @(posedge ref_clk);
      #2;
    end
    repeat (8) @(posedge ref_clk);
    #2;
    ds = strobes - s0;
    dr = nrsp - r0;
    chk("out_idle", 9'h001, {8'h00, lnk.serial_out_line});
  endtask

  task automatic run(input scr_row_s r);
    cmd(r.rd, r.a, r.d);
    if (r.rd) begin
      chk("rsp_data", {1'b0, r.e}, {1'b0, rsp_data});
      chk("rsp_count", 9'h001, 9'(dr));
      chk("short_commit", 9'h000, 9'(ds));
    end else begin
      chk("commit_count", 9'h001, 9'(ds));
      chk("wr_addr", {2'h0, r.a}, {2'h0, reg_wr_addr});
      chk("wr_data", r.d, reg_wr_data);
      if (r.a == READBACK_CTRL_ADDR) exp_rb = r.d[4:0];
      chk("rb_ctrl", {4'h0, exp_rb}, {4'h0, readback_enable, continuous_readback, readback_source_select});
    end
  endtask

  // Main sequence: reset, table rows, continuous sweep, then mode pins.
  initial begin
    fails = 0;
    total_checks = 0;
    cycles = 0;
    strobes = 0;
    nrsp = 0;
    exp_rb = 5'h00;
    reset = 1'b1;
    control_method_select = 1'b0;
    serial_wire_count_select = 1'b1;
    error_status = 8'ha5;
    channel_status = 40'hc9c7c5c3c1;
    spdif_status = 8'h5a;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 7'h00;
    cmd_data = 9'h000;
    repeat (20) @(posedge ref_clk);
    #2;
    reset = 1'b0;
    repeat (6) @(posedge ref_clk);
    #2;
    chk("rb_reset", 9'h000, {4'h0, readback_enable, continuous_readback, readback_source_select});
    chk("modes", 9'h003, {7'h00, software_mode, three_wire_mode});
    foreach (ROWS[i]) run(ROWS[i]);
    for (int k = 0; k < 8; k++) begin
      run('{1'b0, READBACK_CTRL_ADDR, {4'h0, 2'h3, 3'(k)}, 8'h00});
      run('{1'b0, 7'h10, 9'h155, 8'h00});
      run('{1'b1, 7'h00, 9'h000, src(k)});
    end
    run('{1'b0, READBACK_CTRL_ADDR, 9'h01e, 8'h00});
    spdif_status = 8'h3c;
    run('{1'b1, 7'h00, 9'h000, 8'h3c});
    control_method_select = 1'b1;
    repeat (6) @(posedge ref_clk);
    #2;
    chk("hw_mode", 9'h000, {8'h00, software_mode});
    cmd(1'b0, READBACK_CTRL_ADDR, 9'h000);
    chk("hw_commit", 9'h000, 9'(ds));
    control_method_select = 1'b0;
    serial_wire_count_select = 1'b0;
    repeat (6) @(posedge ref_clk);
    #2;
    chk("two_wire", 9'h002, {7'h00, software_mode, three_wire_mode});
    cmd(1'b0, READBACK_CTRL_ADDR, 9'h000);
    chk("two_wire_commit", 9'h000, 9'(ds));
    serial_wire_count_select = 1'b1;
    repeat (6) @(posedge ref_clk);
    #2;
    run('{1'b1, 7'h00, 9'h000, 8'h3c});
    // A second reset in mid-run must bring readback control back to its defaults.
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    #2;
    reset = 1'b0;
    exp_rb = 5'h00;
    repeat (6) @(posedge ref_clk);
    #2;
    chk("rb_rereset", 9'h000, {4'h0, readback_enable, continuous_readback, readback_source_select});
    run('{1'b1, 7'h00, 9'h000, 8'hff});
    run('{1'b0, READBACK_CTRL_ADDR, 9'h008, 8'h00});
    run('{1'b1, 7'h00, 9'h000, 8'hff});
    results();
  end
endmodule
